// [pcc_defines.svh]
// Timing figures, widths and fixed counts of the precharge timing block.
// Assumes the command clock period below; all counts are in its cycles.
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

`define PCC_NUM_BANKS 8
`define PCC_BANK_W 3
`define PCC_CNT_W 8

// Command clock period of the link, in picoseconds.
`define PCC_TCK_PS 125000

// Least times in picoseconds, with their floors in whole clock cycles.
`define PCC_TRAS_PS 42000
`define PCC_TRAS_NCK 3
`define PCC_TRCD_PS 18000
`define PCC_TRCD_NCK 4
`define PCC_TRP_PS 18000
`define PCC_TRP_NCK 3
`define PCC_TRTP_PS 7500
`define PCC_TRTP_NCK 8
`define PCC_TWR_PS 18000
`define PCC_TWR_NCK 6

// Least times round up to whole cycles and never fall below their floor.
`define PCC_CYC_UP(ps) (((ps) + `PCC_TCK_PS - 1) / `PCC_TCK_PS)
`define PCC_MAXC(a, b) (((a) > (b)) ? (a) : (b))
`define PCC_TRAS_CYC `PCC_MAXC(`PCC_CYC_UP(`PCC_TRAS_PS), `PCC_TRAS_NCK)
`define PCC_TRCD_CYC `PCC_MAXC(`PCC_CYC_UP(`PCC_TRCD_PS), `PCC_TRCD_NCK)
`define PCC_TRP_CYC `PCC_MAXC(`PCC_CYC_UP(`PCC_TRP_PS), `PCC_TRP_NCK)
`define PCC_TRC_CYC (`PCC_TRAS_CYC + `PCC_TRP_CYC)
`define PCC_TRTP_CYC `PCC_MAXC(`PCC_CYC_UP(`PCC_TRTP_PS), `PCC_TRTP_NCK)
`define PCC_TWR_CYC `PCC_MAXC(`PCC_CYC_UP(`PCC_TWR_PS), `PCC_TWR_NCK)

// Burst halves in clock cycles and the prefetch group of sixteen beats.
`define PCC_HALF_BL16 8'h08
`define PCC_HALF_BL32 8'h10
`define PCC_PREFETCH_BEATS 16
`define PCC_PREFETCH_HALF 8'h08
`define PCC_ONE_CYC 8'h01

`endif

// [pcc_pkg.sv]
// Types shared by the precharge timing block.
// Assumes commands arrive already decoded from the command/address bus.
package pcc_pkg;

  typedef enum logic [2:0] {
    PCC_CMD_NOP = 3'h0,
    PCC_CMD_ACT = 3'h1,
    PCC_CMD_RD = 3'h2,
    PCC_CMD_WR = 3'h3,
    PCC_CMD_MWR = 3'h4,
    PCC_CMD_PRE = 3'h5,
    PCC_CMD_PREA = 3'h6
  } pcc_cmd_t;

  typedef logic [7:0] pcc_cnt_t;
  typedef logic [7:0] pcc_bank_mask_t;

endpackage

// [pcc_bank_timer.sv]
// One bank's row state, auto-close scheduling and spacing checks.
// Assumes its inputs are one-cycle command strobes on the link clock.
`timescale 1ns/1ps
`include "pcc_defines.svh"

module pcc_bank_timer
  import pcc_pkg::*;
(
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic act,
  input wire logic rd,
  input wire logic wr,
  input wire logic pre,
  input wire logic auto_close_flag,
  input wire logic burst_len_32,
  input wire logic [5:0] write_latency,
  input wire logic [4:0] read_to_close_count,
  input wire logic [5:0] write_recovery_count,
  output logic open_o,
  output logic close_o,
  output logic viol_o
);

  function automatic pcc_cnt_t pcc_tick(input pcc_cnt_t c);
    pcc_tick = (c == 8'h00) ? 8'h00 : c - 8'h01;
  endfunction

  logic open_reg, ap_pend_reg, close_reg, viol_reg;
  pcc_cnt_t ap_cnt_reg, ras_cnt_reg, rcd_cnt_reg, rc_cnt_reg, rp_cnt_reg;
  pcc_cnt_t pre_ok_reg;

  // Burst halves are multiples of the half prefetch group, so write recovery
  // always starts on a group boundary.
  wire pcc_cnt_t half_bl = burst_len_32 ? `PCC_HALF_BL32
    : `PCC_HALF_BL16;
  wire pcc_cnt_t rtp_skew = half_bl - `PCC_PREFETCH_HALF;
  wire pcc_cnt_t rd_ap_gap = rtp_skew + 8'(read_to_close_count);
  wire pcc_cnt_t wr_ap_gap = 8'(write_latency) + half_bl
    + 8'(write_recovery_count) + `PCC_ONE_CYC;
  wire pcc_cnt_t rd_pl_gap = rtp_skew + 8'(`PCC_TRTP_CYC);
  wire pcc_cnt_t wr_pl_gap = 8'(write_latency) + half_bl
    + 8'(`PCC_TWR_CYC) + `PCC_ONE_CYC;
  wire pcc_cnt_t gap = auto_close_flag ? (rd ? rd_ap_gap : wr_ap_gap)
    : (rd ? rd_pl_gap : wr_pl_gap);
  wire pcc_cnt_t gap_m1 = pcc_tick(gap);
  wire col = rd | wr;
  wire col_ok = col & open_reg & ~ap_pend_reg;
  wire ap_fire = ap_pend_reg & (ap_cnt_reg == 8'h00)
    & (ras_cnt_reg == 8'h00) & ~pre;
  wire shut = pre | ap_fire;

  wire bad_act = act & (open_reg | (rp_cnt_reg != 8'h00)
    | (rc_cnt_reg != 8'h00));
  wire bad_col = col & (~open_reg | ap_pend_reg);
  wire bad_rcd = col & auto_close_flag & (rcd_cnt_reg != 8'h00);
  wire bad_pre = pre & open_reg & ((pre_ok_reg != 8'h00)
    | (ras_cnt_reg != 8'h00));
  wire viol_next = bad_act | bad_col | bad_rcd | bad_pre;

  wire open_next = act ? 1'b1 : (shut ? 1'b0 : open_reg);
  wire ap_pend_next = (act | shut) ? 1'b0
    : ((col_ok & auto_close_flag) ? 1'b1 : ap_pend_reg);
  wire pcc_cnt_t ap_cnt_next = (col_ok & auto_close_flag) ? gap_m1
    : pcc_tick(ap_cnt_reg);
  wire pcc_cnt_t pre_ok_next = (col_ok && gap_m1 > pre_ok_reg) ? gap_m1
    : pcc_tick(pre_ok_reg);
  wire pcc_cnt_t ras_next = act ? 8'(`PCC_TRAS_CYC - 1)
    : pcc_tick(ras_cnt_reg);
  wire pcc_cnt_t rcd_next = act ? 8'(`PCC_TRCD_CYC - 1)
    : pcc_tick(rcd_cnt_reg);
  wire pcc_cnt_t rc_next = act ? 8'(`PCC_TRC_CYC - 1)
    : pcc_tick(rc_cnt_reg);
  wire pcc_cnt_t rp_next = shut ? 8'(`PCC_TRP_CYC - 1)
    : pcc_tick(rp_cnt_reg);

  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      open_reg <= 1'b0;
      ap_pend_reg <= 1'b0;
      close_reg <= 1'b0;
      viol_reg <= 1'b0;
      ap_cnt_reg <= 8'h00;
      pre_ok_reg <= 8'h00;
      ras_cnt_reg <= 8'h00;
      rcd_cnt_reg <= 8'h00;
      rc_cnt_reg <= 8'h00;
      rp_cnt_reg <= 8'h00;
    end
    else
    begin
      open_reg <= open_next;
      ap_pend_reg <= ap_pend_next;
      close_reg <= ap_fire;
      viol_reg <= viol_next;
      ap_cnt_reg <= ap_cnt_next;
      pre_ok_reg <= pre_ok_next;
      ras_cnt_reg <= ras_next;
      rcd_cnt_reg <= rcd_next;
      rc_cnt_reg <= rc_next;
      rp_cnt_reg <= rp_next;
    end
  end

  assign open_o = open_reg;
  assign close_o = close_reg;
  assign viol_o = viol_reg;

  AST_LOCKOUT: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    $rose(close_reg) |-> $past(ras_cnt_reg) == 8'h00)
    else $error("Auto close fired before the least active time.");
  AST_AP_ENGAGE: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    col_ok && auto_close_flag && !pre
    |=> ap_pend_reg ##[0:255] close_reg)
    else $error("Auto close was not scheduled and carried out.");
  AST_STAY_OPEN: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    col_ok && !auto_close_flag && !ap_pend_reg
    && !pre |=> open_reg && !ap_pend_reg)
    else $error("Plain column command closed the bank.");
  AST_RD_GAP16: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    col_ok && rd && auto_close_flag
    && !burst_len_32 && read_to_close_count != 5'h00
    |=> ap_cnt_reg == 8'(read_to_close_count) - 8'h01)
    else $error("Read auto close delay wrong for burst 16.");
  AST_RD_GAP32: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    col_ok && rd && auto_close_flag && burst_len_32
    |=> ap_cnt_reg == 8'(read_to_close_count) + 8'h07)
    else $error("Read auto close delay wrong for burst 32.");
  // Latency, burst length and recovery count are static, so the current
  // values are the ones that were loaded.
  AST_WR_GAP: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    col_ok && wr && auto_close_flag
    |=> ap_cnt_reg == 8'(write_latency) + half_bl
    + 8'(write_recovery_count))
    else $error("Write auto close delay wrong.");
  AST_CLOSE_SHUTS: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    $rose(close_reg) |-> !open_reg
    && rp_cnt_reg == 8'(`PCC_TRP_CYC - 1))
    else $error("Auto close did not start the precharge period.");
  AST_BAD_ACT: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    act && rp_cnt_reg != 8'h00 |=> viol_reg)
    else $error("Activate inside the precharge period not flagged.");
  AST_BAD_COL: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    col && ap_pend_reg |=> viol_reg)
    else $error("Column command to a closing bank not flagged.");
  COV_RD32_CLOSE: cover property (@(posedge link_clk)
    col_ok && rd && auto_close_flag && burst_len_32 ##[1:64] close_reg);
  COV_WR_CLOSE: cover property (@(posedge link_clk)
    col_ok && wr && auto_close_flag ##[1:160] close_reg);

endmodule

// [pcc_precharge_ctrl.sv]
// Precharge and auto-precharge sequencing for eight banks of one channel.
// Assumes decoded commands arrive on the free-running link command clock;
// status is carried over to the mclk domain for the rest of the chip.
//
// Overview of operation
// - Read-to-precharge time starts half burst minus eight after read.
// - Writes land in sixteen-beat groups, recovery starts at a boundary.
// - Auto-close flag high on column command closes the bank itself.
// - Auto-close flag low leaves the bank open after the burst.
// - Internal close waits until the least active time is met.
// - Read auto close starts read-to-close count later, plus eight for 32.
// - Write auto close starts recovery cycles after the write burst.
// - Read auto close uses the programmed read-to-close count.
// - Write auto close uses the programmed write-recovery count.
`timescale 1ns/1ps
`include "pcc_defines.svh"

module pcc_precharge_ctrl
  import pcc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire pcc_cmd_t cmd_kind,
  input wire logic [2:0] cmd_bank,
  input wire logic auto_close_flag,
  input wire logic burst_len_32,
  input wire logic [5:0] write_latency,
  input wire logic [4:0] read_to_close_count,
  input wire logic [5:0] write_recovery_count,
  input wire logic violation_clear,
  output pcc_bank_mask_t bank_open,
  output pcc_bank_mask_t close_bank_mask,
  output logic close_event,
  output logic violation,
  output logic violation_seen
);

  // Reset reaches the link domain through two flops; the link clock runs
  // free, so the synchronised reset is then used synchronously there.
  logic lrst_s1_reg, lrst_s2_reg;

  always_ff @(posedge link_clk)
  begin
    lrst_s1_reg <= rst_n;
    lrst_s2_reg <= lrst_s1_reg;
  end

  wire link_rst_n = lrst_s2_reg;

  // Command decode on the link side.
  wire is_act = cmd_valid & (cmd_kind == PCC_CMD_ACT);
  wire is_rd = cmd_valid & (cmd_kind == PCC_CMD_RD);
  wire is_wr = cmd_valid & ((cmd_kind == PCC_CMD_WR)
    | (cmd_kind == PCC_CMD_MWR));
  wire is_pre = cmd_valid & (cmd_kind == PCC_CMD_PRE);
  wire is_prea = cmd_valid & (cmd_kind == PCC_CMD_PREA);
  wire pcc_bank_mask_t bank_hit = 8'h01 << cmd_bank;

  pcc_bank_mask_t lk_open, lk_close, lk_viol;
  pcc_bank_mask_t close_tgl_reg;
  logic viol_tgl_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `PCC_NUM_BANKS; gi++)
    begin : g_bank
      pcc_bank_timer u_timer (
        .link_clk(link_clk),
        .link_rst_n(link_rst_n),
        .act(is_act & bank_hit[gi]),
        .rd(is_rd & bank_hit[gi]),
        .wr(is_wr & bank_hit[gi]),
        .pre(is_prea | (is_pre & bank_hit[gi])),
        .auto_close_flag(auto_close_flag),
        .burst_len_32(burst_len_32),
        .write_latency(write_latency),
        .read_to_close_count(read_to_close_count),
        .write_recovery_count(write_recovery_count),
        .open_o(lk_open[gi]),
        .close_o(lk_close[gi]),
        .viol_o(lk_viol[gi])
      );
    end
  endgenerate

  // Events become toggles so that a pulse on the slow link clock is never
  // lost or doubled on the fast side.
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      close_tgl_reg <= 8'h00;
      viol_tgl_reg <= 1'b0;
    end
    else
    begin
      close_tgl_reg <= close_tgl_reg ^ lk_close;
      viol_tgl_reg <= viol_tgl_reg ^ (|lk_viol);
    end
  end

  // Two-flop synchronisers plus a history stage for edge detection.
  pcc_bank_mask_t open_s1_reg, open_s2_reg;
  pcc_bank_mask_t ctg_s1_reg, ctg_s2_reg, ctg_s3_reg;
  logic vtg_s1_reg, vtg_s2_reg, vtg_s3_reg;
  pcc_bank_mask_t close_mask_reg;
  logic close_ev_reg, viol_reg, viol_seen_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      open_s1_reg <= 8'h00;
      open_s2_reg <= 8'h00;
      ctg_s1_reg <= 8'h00;
      ctg_s2_reg <= 8'h00;
      ctg_s3_reg <= 8'h00;
      vtg_s1_reg <= 1'b0;
      vtg_s2_reg <= 1'b0;
      vtg_s3_reg <= 1'b0;
    end
    else
    begin
      open_s1_reg <= lk_open;
      open_s2_reg <= open_s1_reg;
      ctg_s1_reg <= close_tgl_reg;
      ctg_s2_reg <= ctg_s1_reg;
      ctg_s3_reg <= ctg_s2_reg;
      vtg_s1_reg <= viol_tgl_reg;
      vtg_s2_reg <= vtg_s1_reg;
      vtg_s3_reg <= vtg_s2_reg;
    end
  end

  wire pcc_bank_mask_t close_edge = ctg_s2_reg ^ ctg_s3_reg;
  wire viol_edge = vtg_s2_reg ^ vtg_s3_reg;
  // A new violation in the clearing cycle keeps the sticky flag set.
  wire viol_seen_next = viol_edge | (viol_seen_reg & ~violation_clear);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      close_mask_reg <= 8'h00;
      close_ev_reg <= 1'b0;
      viol_reg <= 1'b0;
      viol_seen_reg <= 1'b0;
    end
    else
    begin
      close_mask_reg <= close_edge;
      close_ev_reg <= |close_edge;
      viol_reg <= viol_edge;
      viol_seen_reg <= viol_seen_next;
    end
  end

  assign bank_open = open_s2_reg;
  assign close_bank_mask = close_mask_reg;
  assign close_event = close_ev_reg;
  assign violation = viol_reg;
  assign violation_seen = viol_seen_reg;

  AST_PREA_ALL: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    is_prea |=> lk_open == 8'h00)
    else $error("All-bank precharge left a bank open.");
  AST_ACT_OPENS: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    is_act |=> lk_open[$past(cmd_bank)])
    else $error("Activate did not open the addressed bank.");
  AST_VIOL_CROSS: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (|lk_viol) |=> viol_tgl_reg != $past(viol_tgl_reg))
    else $error("Violation event not handed to the system side.");
  AST_STICKY: assert property (
    @(posedge mclk) disable iff (!rst_n)
    viol_edge |=> violation_seen && violation)
    else $error("Violation not reported on the system side.");
  AST_CLOSE_REPORT: assert property (
    @(posedge mclk) disable iff (!rst_n)
    close_edge != 8'h00 |=> close_event
    && close_bank_mask == $past(close_edge))
    else $error("Auto close not reported with its bank.");
  COV_VIOL: cover property (@(posedge mclk) violation ##1 violation_clear);
  COV_CLOSE: cover property (@(posedge mclk) close_event);
  COV_ACT_RD_AP: cover property (@(posedge link_clk)
    is_act ##[1:20] is_rd && auto_close_flag);

endmodule

// [pcc_mc_model.sv]
// Memory controller model that issues decoded commands on the link clock.
// Assumes the bench calls send; spacing is chosen by the caller.
`timescale 1ns/1ps

module pcc_mc_model
  import pcc_pkg::*;
(
  input wire logic link_clk,
  output logic cmd_valid,
  output pcc_cmd_t cmd_kind,
  output logic [2:0] cmd_bank,
  output logic auto_close_flag
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_kind = PCC_CMD_NOP;
    cmd_bank = 3'h0;
    auto_close_flag = 1'b0;
  end

  // The command is taken on the d-th link edge after send is called.
  // d must be at least 2 so no line is driven twice in one time step.
  task automatic send(input pcc_cmd_t k, input logic [2:0] b,
    input logic ap, input int d);
    repeat (d - 1)
      @(posedge link_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_bank <= b;
    auto_close_flag <= ap;
    @(posedge link_clk);
    // Released lines show NOP or the inverse so a stale value never looks valid.
    cmd_valid <= 1'b0;
    cmd_kind <= PCC_CMD_NOP;
    cmd_bank <= ~b;
    auto_close_flag <= ~ap;
  endtask
endmodule

// [precharge_timing_ctrl_tb_top.sv]
// Self-checking bench for the precharge timing block.
// Assumes the design files and pcc_mc_model.sv are compiled first.
`timescale 1ns/1ps
`include "pcc_defines.svh"

module precharge_timing_ctrl_tb_top;
  import pcc_pkg::*;
  logic mclk, link_clk, rst_n, burst_len_32, violation_clear;
  logic cmd_valid, auto_close_flag, close_event, violation, violation_seen;
  pcc_cmd_t cmd_kind;
  logic [2:0] cmd_bank;
  logic [5:0] write_latency, write_recovery_count;
  logic [4:0] read_to_close_count;
  pcc_bank_mask_t bank_open, close_bank_mask, last_mask;
  int lcnt, cyc, n_close, n_viol, t_close, err_total, compares;
  pcc_cmd_t vk2[7] = '{PCC_CMD_NOP, PCC_CMD_RD, PCC_CMD_PRE, PCC_CMD_RD,
    PCC_CMD_PRE, PCC_CMD_WR, PCC_CMD_MWR};
  pcc_cmd_t vk3[7] = '{PCC_CMD_ACT, PCC_CMD_NOP, PCC_CMD_NOP, PCC_CMD_PRE,
    PCC_CMD_ACT, PCC_CMD_WR, PCC_CMD_PRE};
  int vd2[7] = '{8, 2, 2, 4, 8, 4, 4};
  int vd3[7] = '{2, 2, 2, 4, 2, 4, 8};
  logic [6:0] va2 = 7'h22;

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // The link clock is offset so its edges never line up with mclk.
  initial
  begin
    link_clk = 1'b0;
    #1.3;
    forever #62.5 link_clk = ~link_clk;
  end

  pcc_precharge_ctrl DUT (.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank),
    .auto_close_flag(auto_close_flag), .burst_len_32(burst_len_32),
    .write_latency(write_latency),
    .read_to_close_count(read_to_close_count),
    .write_recovery_count(write_recovery_count),
    .violation_clear(violation_clear), .bank_open(bank_open),
    .close_bank_mask(close_bank_mask), .close_event(close_event),
    .violation(violation), .violation_seen(violation_seen));

  pcc_mc_model mc (.link_clk(link_clk), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_bank(cmd_bank),
    .auto_close_flag(auto_close_flag));

  always @(posedge link_clk)
    lcnt <= lcnt + 1;

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (close_event === 1'b1)
    begin
      n_close <= n_close + 1;
      t_close <= lcnt;
      last_mask <= close_bank_mask;
    end
    if (violation === 1'b1)
      n_viol <= n_viol + 1;
    if (cyc == 95000)
    begin
      err_total++;
      end_sim();
    end
  end

  function automatic int half_bl();
    return burst_len_32 ? 16 : 8;
  endfunction

  // Link cycles from an auto-closing column command to the internal close.
  function automatic int close_gap(pcc_cmd_t k);
    if (k == PCC_CMD_RD)
      return half_bl() - 8 + read_to_close_count;
    return write_latency + half_bl() + write_recovery_count + 1;
  endfunction

  function automatic int pre_gap(pcc_cmd_t k);
    if (k == PCC_CMD_RD)
      return half_bl() - 8 + `PCC_TRTP_CYC;
    return write_latency + half_bl() + 1 + `PCC_TWR_CYC;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string msg);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s seen %0h exp %0h", $time, msg, seen,
        exp);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic run_one(input logic [2:0] b, input pcc_cmd_t k,
    input logic ap);
    int t0, bc, bv, g;
    bc = n_close;
    bv = n_viol;
    mc.send(PCC_CMD_ACT, b, 1'b0, 8);
    mc.send(k, b, ap, `PCC_TRCD_CYC);
    t0 = lcnt + 1;
    g = ap ? close_gap(k) : pre_gap(k);
    repeat (2)
      @(posedge link_clk);
    check(bank_open[b], 1'b1, "bank not open");
    if (ap)
      repeat (g + 2)
        @(posedge link_clk);
    else
      mc.send(PCC_CMD_PRE, b, 1'b0, g - 2);
    repeat (4)
      @(posedge link_clk);
    check(n_close - bc, ap, "auto close count");
    check(n_viol - bv, 0, "legal sequence flagged");
    check(bank_open[b], 1'b0, "bank still open");
    if (ap)
    begin
      check(t_close, t0 + g + 1, "close time");
      check(last_mask, 8'h01 << b, "close mask");
    end
  endtask

  task automatic run_viol(input int i, input logic [2:0] b);
    int bv;
    bv = n_viol;
    mc.send(PCC_CMD_ACT, b, 1'b0, 8);
    mc.send(vk2[i], b, va2[i], vd2[i]);
    mc.send(vk3[i], b, 1'b0, vd3[i]);
    repeat (40)
      @(posedge link_clk);
    check(n_viol - bv, 1, "violations");
    check(violation_seen, 1'b1, "sticky flag low");
    @(posedge mclk);
    violation_clear <= 1'b1;
    @(posedge mclk);
    violation_clear <= 1'b0;
    mc.send(PCC_CMD_PREA, b, 1'b0, 2);
    repeat (6)
      @(posedge link_clk);
    check(violation_seen, 1'b0, "sticky flag not cleared");
    check(bank_open, 8'h00, "bank open after close all");
  endtask

  initial
  begin
    rst_n = 1'b0;
    violation_clear = 1'b0;
    burst_len_32 = 1'b0;
    write_latency = 6'h04;
    read_to_close_count = 5'h08;
    write_recovery_count = 6'h06;
    void'($urandom(72));
    // Reset spans link edges too, since it reaches that domain late.
    repeat (12)
      @(posedge link_clk);
    check({bank_open, close_event, violation, violation_seen}, 32'h0,
      "outputs during reset");
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4)
      @(posedge link_clk);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge link_clk);
      burst_len_32 <= p[0];
      write_latency <= 6'(4 + $urandom % 7);
      read_to_close_count <= 5'(8 + $urandom % 8);
      write_recovery_count <= 6'(6 + $urandom % 7);
      repeat (4)
        @(posedge link_clk);
      for (int j = 0; j < 6; j++)
        run_one(3'(j), pcc_cmd_t'(3'(2 + j % 3)), j >= 3);
      for (int j = 0; j < 6; j++)
        run_one(3'($urandom), pcc_cmd_t'(3'(2 + $urandom % 3)),
          1'($urandom));
      for (int j = 0; j < 7; j++)
        run_viol(j, 3'($urandom));
      $display("test pass %0d done, burst 32 = %0d", p, p);
    end
    end_sim();
  end
endmodule
